// [rtl/ascs_pkg.sv]
// Contract
// - With stop-on-first-irq set, first converter interrupt clears auto-sample-start.
// - With stop-on-first-irq clear, sequences keep running and overwrite results.
// - Auto-sample-start set: sampling restarts after conversion, sample-enable set by hardware.
// - Auto-sample-start clear: sampling starts only when software writes sample-enable one.
// - Sample-enable reads one while sampling, zero while holding.
// - Trigger source zero: software writing sample-enable zero ends sampling, starts conversion.
// - Trigger source nonzero: hardware clears sample-enable and starts conversion.
// - Conversion-complete sets when a conversion finishes; reads zero otherwise.
// - Software clears conversion-complete by writing zero; clear never disturbs conversion.
// - Conversion-complete clears automatically when a new conversion starts.
package ascs_pkg;
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] RESULT_OFFSET = 4'h4;
    localparam logic [3:0] CFG_OFFSET = 4'h8;
    localparam int DONE_BIT = 0;
    localparam int SAMPLE_ENABLE_BIT = 1;
    localparam int AUTO_BIT = 2;
    localparam int STOP_BIT = 4;
    localparam int TRIG_LSB = 5;
    localparam int TRIG_W = 3;
    localparam int ON_BIT = 15;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] SAMPLE_CYCLES_RESET = 8'h04;
    localparam logic [7:0] CONV_CYCLES_RESET = 8'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] TRIG_MANUAL = 3'h0;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } ascs_state_t;
endpackage : ascs_pkg

// [rtl/ascs_adc_sequencer.sv]
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ascs_adc_sequencer #(
    parameter int RESULT_W = 10
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic convTrigger,
    input wire logic [RESULT_W-1:0] adcData,
    output logic sampling,
    output logic convIrq
);
    import ascs_pkg::*;

    ascs_state_t state_q, state_d;
    logic moduleOn_q, stopOnFirstIrq_q, autoSampleStart_q, sampleEnable_q, convDone_q;
    logic [TRIG_W-1:0] trigSource_q;
    logic [7:0] sampleCycles_q, convCycles_q, count_q;
    logic [RESULT_W-1:0] result_q;
    logic trigS1_q, trigS2_q, trigS3_q;
    logic awHeld_q, wHeld_q;
    logic [3:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic sampling_q, convIrq_q;
    logic awReady_q, wReady_q, arReady_q;
    logic trigPrev_q;

    // Write channel capture, either order
    wire awTake = s_axi_awvalid && awReady_q;
    wire wTake = s_axi_wvalid && wReady_q;
    wire awHave = awHeld_q || awTake;
    wire wHave = wHeld_q || wTake;
    wire [3:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
    wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
    wire [3:0] wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
    wire wrFire = awHave && wHave && !s_axi_bvalid;
    wire wrCtrl = wrFire && wrAddr == CTRL_OFFSET && wrStrb[0];
    wire wrCtrlHi = wrFire && wrAddr == CTRL_OFFSET && wrStrb[1];
    wire wrCfg = wrFire && wrAddr == CFG_OFFSET;
    wire wrOk = wrAddr == CTRL_OFFSET || wrAddr == CFG_OFFSET || wrAddr == RESULT_OFFSET;
    wire bHold = s_axi_bvalid && !s_axi_bready;
    wire rdTake = s_axi_arvalid && arReady_q;
    wire rHold = s_axi_rvalid && !s_axi_rready;
    wire rdOk = s_axi_araddr == CTRL_OFFSET || s_axi_araddr == CFG_OFFSET || s_axi_araddr == RESULT_OFFSET;

    // Trigger pin, counted once stages two and three agree
    wire trigRise = trigS2_q && trigS3_q && !trigPrev_q;
    wire [TRIG_W-1:0] newTrig = wrCtrl ? wrData[TRIG_LSB +: TRIG_W] : trigSource_q;
    wire swStart = wrCtrl && wrData[SAMPLE_ENABLE_BIT] && !sampleEnable_q && !autoSampleStart_q;
    wire swEnd = wrCtrl && !wrData[SAMPLE_ENABLE_BIT] && sampleEnable_q && trigSource_q == TRIG_MANUAL;
    wire countDone = count_q == 8'h00;
    wire hwEnd = sampleEnable_q && trigSource_q != TRIG_MANUAL
        && (trigSource_q == TRIG_AUTO ? countDone : trigRise);
    wire inSample = state_q == ST_SAMPLE;
    wire enterSample = state_d == ST_SAMPLE && state_q != ST_SAMPLE;
    wire convStart = moduleOn_q && inSample && (swEnd || hwEnd);
    wire convFinish = moduleOn_q && state_q == ST_CONVERT && countDone;
    wire autoRestart = convFinish && autoSampleStart_q && !stopOnFirstIrq_q;
    logic [31:0] ctrlRead;
    assign ctrlRead = {
        16'h0000,
        moduleOn_q,
        7'h00,
        trigSource_q,
        stopOnFirstIrq_q,
        1'b0,
        autoSampleStart_q,
        sampleEnable_q,
        convDone_q
    };
    wire [31:0] cfgRead = {16'h0000, convCycles_q, sampleCycles_q};
    wire [31:0] resultRead = {{(32 - RESULT_W){1'b0}}, result_q};
    wire [31:0] rdData = s_axi_araddr == CTRL_OFFSET ? ctrlRead
        : s_axi_araddr == CFG_OFFSET ? cfgRead
        : s_axi_araddr == RESULT_OFFSET ? resultRead : 32'h0000_0000;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (moduleOn_q && (swStart || (autoSampleStart_q && !stopOnFirstIrq_q)
                    || (wrCtrl && wrData[AUTO_BIT] && !wrData[STOP_BIT]))) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (convStart) begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (convFinish) begin
                    state_d = autoRestart ? ST_SAMPLE : ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (!moduleOn_q) begin
            state_d = ST_IDLE;
        end
    end

    // Three stage synchroniser for the trigger pin
    always_ff @(posedge mclk) begin
        trigS1_q <= convTrigger;
        trigS2_q <= trigS1_q;
        trigS3_q <= trigS2_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            trigPrev_q <= 1'b0;
        end else if (trigS2_q == trigS3_q) begin
            trigPrev_q <= trigS3_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
        end else begin
            awHeld_q <= awHave && !wrFire;
            if (awTake) begin
                awAddr_q <= s_axi_awaddr;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else begin
            wHeld_q <= wHave && !wrFire;
            if (wTake) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
        end
    end

    // Ready flags low while a word is held or a response waits
    always_ff @(posedge mclk) begin
        if (rst) begin
            awReady_q <= 1'b0;
            wReady_q <= 1'b0;
        end else begin
            awReady_q <= !awHave && !bHold;
            wReady_q <= !wHave && !bHold;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            arReady_q <= 1'b0;
        end else begin
            arReady_q <= !rdTake && !rHold;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rdTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData;
            s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_arready = arReady_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            moduleOn_q <= CTRL_RESET[ON_BIT];
        end else if (wrCtrlHi) begin
            moduleOn_q <= wrData[ON_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            trigSource_q <= CTRL_RESET[TRIG_LSB +: TRIG_W];
        end else if (wrCtrl) begin
            trigSource_q <= newTrig;
        end
    end

    // Sample length for the internal trigger
    always_ff @(posedge mclk) begin
        if (rst) begin
            sampleCycles_q <= SAMPLE_CYCLES_RESET;
        end else if (wrCfg && wrStrb[0]) begin
            sampleCycles_q <= wrData[7:0];
        end
    end

    // Conversion length
    always_ff @(posedge mclk) begin
        if (rst) begin
            convCycles_q <= CONV_CYCLES_RESET;
        end else if (wrCfg && wrStrb[1]) begin
            convCycles_q <= wrData[15:8];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stopOnFirstIrq_q <= CTRL_RESET[STOP_BIT];
        end else if (wrCtrl) begin
            stopOnFirstIrq_q <= wrData[STOP_BIT];
        end
    end

    // Hardware clear of auto start wins over a write in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            autoSampleStart_q <= CTRL_RESET[AUTO_BIT];
        end else if (convFinish && stopOnFirstIrq_q) begin
            autoSampleStart_q <= 1'b0;
        end else if (wrCtrl) begin
            autoSampleStart_q <= wrData[AUTO_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sampleEnable_q <= 1'b0;
        end else begin
            sampleEnable_q <= state_d == ST_SAMPLE;
        end
    end

    // One counter serves the sample phase and the conversion
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q <= 8'h00;
        end else if (enterSample) begin
            count_q <= sampleCycles_q;
        end else if (convStart) begin
            count_q <= convCycles_q;
        end else if (!countDone) begin
            count_q <= count_q - 8'h01;
        end
    end

    // Finish sets the flag and beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            convDone_q <= 1'b0;
        end else if (convFinish) begin
            convDone_q <= 1'b1;
        end else if (convStart) begin
            convDone_q <= 1'b0;
        end else if (wrCtrl && !wrData[DONE_BIT]) begin
            convDone_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            result_q <= '0;
        end else if (convFinish) begin
            result_q <= adcData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            convIrq_q <= 1'b0;
        end else begin
            convIrq_q <= convFinish;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sampling_q <= 1'b0;
        end else begin
            sampling_q <= state_d == ST_SAMPLE;
        end
    end

    assign sampling = sampling_q;
    assign convIrq = convIrq_q;
endmodule : ascs_adc_sequencer

// [tb/ascs_adc_sequencer_props.sv]
`timescale 1ns/1ps
module ascs_adc_sequencer_props
    import ascs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic sampling,
    input wire logic convIrq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire takeW = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire takeR = s_axi_arvalid && s_axi_arready;
    wire badR = s_axi_araddr != CTRL_OFFSET && s_axi_araddr != RESULT_OFFSET && s_axi_araddr != CFG_OFFSET;
    a_irq_one_cycle: assert property (convIrq |=> !convIrq) else $error("irq too long");
    a_irq_after_hold: assert property (convIrq |-> !$past(sampling)) else $error("irq while sampling");
    a_conv_follows: assert property ($fell(sampling) |-> ##[1:40] convIrq) else $error("no conversion");
    a_sample_enable_readback: assert property (takeR && s_axi_araddr == CTRL_OFFSET |=>
        s_axi_rdata[SAMPLE_ENABLE_BIT] == $past(sampling)) else $error("sample bit mismatch");
    a_wr_answer: assert property (takeW |=> s_axi_bvalid) else $error("no write response");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("extra response");
    a_rd_answer: assert property (takeR |=> s_axi_rvalid) else $error("no read response");
    a_rd_resp_code: assert property (takeR |=> s_axi_rresp == ($past(badR) ? RESP_SLVERR : RESP_OKAY))
        else $error("read response code");
    cover property (convIrq);
    cover property ($rose(sampling));
    cover property (takeR && badR);
endmodule : ascs_adc_sequencer_props
bind ascs_adc_sequencer ascs_adc_sequencer_props ascs_adc_sequencer_props_i (.*);

// [tb/test_adc_sample_convert_sequencer.sv]
`timescale 1ns/1ps
module test_adc_sample_convert_sequencer;
    import ascs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, seed = 32'h12, rd, ex;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, convTrigger = 1'b0;
    logic [9:0] adcData = 10'h0;
    logic [1:0] rsp;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sampling, convIrq;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    int num_errors = 0, comparisons = 0, cycles = 0, c;
    ascs_adc_sequencer ascs_adc_sequencer_i (.*);
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    function automatic logic [31:0] nextRand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : nextRand
    function automatic logic [31:0] ctrlWord(input logic [2:0] trig, input logic stop, auto, sample_enable, done);
        return (32'h1 << ON_BIT) | {24'h0, trig, stop, 1'b0, auto, sample_enable, done};
    endfunction : ctrlWord
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin @(posedge mclk); n++; end while (!(s_axi_awready && s_axi_wready) && n < 99);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do begin @(posedge mclk); n++; end while (!s_axi_bvalid && n < 99);
        if (n >= 99) num_errors++;
        rsp = s_axi_bresp;
    endtask : axw
    task automatic axr(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin @(posedge mclk); n++; end while (!s_axi_arready && n < 99);
        s_axi_arvalid <= 1'b0;
        do begin @(posedge mclk); n++; end while (!s_axi_rvalid && n < 99);
        if (n >= 99) num_errors++;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : axr
    task automatic waitIrq();
        int n;
        n = 0;
        do begin @(posedge mclk); n++; end while (!convIrq && n < 200);
        chk(32'(n < 200), 32'h1);
    endtask : waitIrq
    task automatic countIrq(input int len);
        c = 0;
        repeat (len) begin
            @(posedge mclk);
            if (convIrq) c++;
        end
    endtask : countIrq
    task summarize();
        $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        axr(CTRL_OFFSET); chk(rd, CTRL_RESET);
        axr(CFG_OFFSET); chk(rd, {16'h0, CONV_CYCLES_RESET, SAMPLE_CYCLES_RESET});
        axr(4'hc); chk(rsp, RESP_SLVERR);
        axw(4'hc, 32'h0); chk(rsp, RESP_SLVERR);
        axw(RESULT_OFFSET, 32'hffff_ffff); chk(rsp, RESP_OKAY);
        axw(CTRL_OFFSET, ctrlWord(TRIG_MANUAL, 0, 0, 0, 0));
        for (int k = 0; k < 2; k++) begin
            axw(CTRL_OFFSET, ctrlWord(TRIG_MANUAL, 0, 0, 1, k[0]));
            repeat (8) @(posedge mclk);
            chk(sampling, 1);
            ex = nextRand();
            adcData <= ex[9:0];
            axw(CTRL_OFFSET, ctrlWord(TRIG_MANUAL, 0, 0, 0, k[0]));
            axr(CTRL_OFFSET); chk(rd[1:0], 0);
            waitIrq();
            axr(RESULT_OFFSET); chk(rd[9:0], ex[9:0]);
            axr(CTRL_OFFSET); chk(rd[1:0], 1);
        end
        axw(CTRL_OFFSET, ctrlWord(TRIG_MANUAL, 0, 0, 0, 0));
        axr(CTRL_OFFSET); chk(rd[1:0], 0);
        for (int t = 1; t < 7; t++) begin
            axw(CTRL_OFFSET, ctrlWord(t[2:0], 0, 0, 1, 1));
            repeat (6) @(posedge mclk);
            chk(sampling, 1);
            convTrigger <= 1'b1;
            waitIrq();
            convTrigger <= 1'b0;
            axr(CTRL_OFFSET); chk(rd[1:0], 1);
        end
        axw(CTRL_OFFSET, ctrlWord(TRIG_AUTO, 1, 1, 1, 0));
        waitIrq();
        repeat (3) @(posedge mclk);
        axr(CTRL_OFFSET); chk(rd[2:0], 3'b001);
        countIrq(60); chk(c, 0);
        axw(CTRL_OFFSET, ctrlWord(TRIG_AUTO, 0, 1, 1, 0));
        waitIrq();
        repeat (2) @(posedge mclk);
        chk(sampling, 1);
        countIrq(100); chk(32'(c >= 3), 1);
        axw(CTRL_OFFSET, ctrlWord(TRIG_AUTO, 0, 0, 0, 0));
        waitIrq();
        repeat (3) @(posedge mclk);
        axw(CTRL_OFFSET, 32'h0);
        repeat (2) @(posedge mclk);
        axr(CTRL_OFFSET); chk(rd, CTRL_RESET);
        chk(sampling, 0);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        axr(CTRL_OFFSET); chk(rd, CTRL_RESET);
        summarize();
    end
endmodule : test_adc_sample_convert_sequencer
